// File: pkg/igtdp_consts.svh
`ifndef IGTDP_CONSTS_SVH
`define IGTDP_CONSTS_SVH

// ==========================================
// register offsets (byte addresses)
`define IGTDP_OFF_ISR      8'h10
`define IGTDP_OFF_IMR      8'h14
`define IGTDP_OFF_GATE     8'h18
`define IGTDP_OFF_TX_DESCRIPTOR_POINTER     8'h20
`define IGTDP_OFF_CMD      8'h04
`define IGTDP_OFF_EVRAW    8'h28

// ==========================================
// field positions
`define IGTDP_GATE_EN_BIT  0
`define IGTDP_CMD_TXE_BIT  0
`define IGTDP_TX_DESCRIPTOR_POINTER_LSB     2
`define IGTDP_NUM_EVENTS   4

// ==========================================
// reset values
`define IGTDP_GATE_RST     32'h0000_0000
`define IGTDP_TX_DESCRIPTOR_POINTER_RST     32'h0000_0000
`define IGTDP_STAT_RST     4'h0
`define IGTDP_MASK_RST     4'h0
`define IGTDP_GATE_EN_RST  1'b0
`define IGTDP_LINK_RST     32'h0000_0000

`endif

// File: pkg/igtdp_pkg.sv
package igtdp_pkg;

    typedef enum logic [1:0] {
        IGTDP_TX_IDLE,
        IGTDP_TX_FETCH,
        IGTDP_TX_SEND,
        IGTDP_TX_PARK
    } igtdp_tx_state_type;

    typedef logic [31:0] igtdp_word_type;
    typedef logic [3:0]  igtdp_evt_type;

endpackage

// File: core/igtdp_irq_gate.sv
`timescale 1ns/1ns
`include "igtdp_consts.svh"

module igtdp_irq_gate (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire igtdp_pkg::igtdp_evt_type event_i,
    input  wire logic                   clr_we_i,
    input  wire igtdp_pkg::igtdp_evt_type clr_data_i,
    input  wire logic                   mask_we_i,
    input  wire igtdp_pkg::igtdp_evt_type mask_data_i,
    input  wire logic                   enable_i,
    output logic                        irq_o,
    output igtdp_pkg::igtdp_evt_type    status_o,
    output igtdp_pkg::igtdp_evt_type    mask_o
);
    import igtdp_pkg::*;

    typedef struct packed {
        igtdp_evt_type status;
        igtdp_evt_type mask;
        logic          irq;
    } igtdp_irq_state_type;

    igtdp_irq_state_type state_reg;
    igtdp_irq_state_type state_next;

    // ==========================================
    // sticky status, mask, gated line
    always_comb begin
        state_next = state_reg;
        if (clr_we_i) begin
            state_next.status = state_reg.status & ~clr_data_i;
        end
        // set wins over clear, mask ignored
        state_next.status = state_next.status | event_i;
        if (mask_we_i) begin
            state_next.mask = mask_data_i;
        end
        // line gated by enable bit
        state_next.irq = enable_i &&
            (|(state_next.status & state_next.mask));
        if (!enable_i) begin
            state_next.irq = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.status <= `IGTDP_STAT_RST;
            state_reg.mask   <= `IGTDP_MASK_RST;
            state_reg.irq    <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign irq_o    = state_reg.irq;
    assign status_o = state_reg.status;
    assign mask_o   = state_reg.mask;

endmodule

// File: core/igtdp_tx_walker.sv
`timescale 1ns/1ns
`include "igtdp_consts.svh"

module igtdp_tx_walker (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     txe_write_i,
    input  wire logic                     txe_value_i,
    input  wire logic                     tx_descriptor_pointer_we_i,
    input  wire igtdp_pkg::igtdp_word_type tx_descriptor_pointer_data_i,
    output logic                          fetch_req_o,
    output igtdp_pkg::igtdp_word_type     fetch_addr_o,
    input  wire logic                     fetch_ack_i,
    input  wire igtdp_pkg::igtdp_word_type link_i,
    input  wire logic                     desc_done_i,
    output igtdp_pkg::igtdp_word_type     tx_descriptor_pointer_o,
    output logic                          active_o,
    output logic                          advance_o,
    output logic                          end_of_list_o
);
    import igtdp_pkg::*;

    typedef struct packed {
        igtdp_tx_state_type st;
        igtdp_word_type     ptr;
        igtdp_word_type     link;
        logic               adv;
        logic               eol;
    } igtdp_walk_state_type;

    igtdp_walk_state_type state_reg;
    igtdp_walk_state_type state_next;

    function automatic igtdp_word_type align_word(input igtdp_word_type a);
        align_word = {a[31:`IGTDP_TX_DESCRIPTOR_POINTER_LSB], 2'b00};
    endfunction

    // ==========================================
    // linked list walk
    always_comb begin
        state_next     = state_reg;
        state_next.adv = 1'b0;
        state_next.eol = 1'b0;
        case (state_reg.st)
            IGTDP_TX_IDLE: begin
                if (tx_descriptor_pointer_we_i) begin
                    state_next.ptr = align_word(tx_descriptor_pointer_data_i);
                end
                if (txe_write_i && txe_value_i) begin
                    state_next.st = IGTDP_TX_FETCH;
                end
            end
            IGTDP_TX_FETCH: begin
                if (fetch_ack_i) begin
                    // link only valid with the ack pulse
                    state_next.link = link_i;
                    if (link_i == 32'h0000_0000) begin
                        state_next.st  = IGTDP_TX_PARK;
                        state_next.eol = 1'b1;
                    end else begin
                        state_next.st = IGTDP_TX_SEND;
                    end
                end
            end
            IGTDP_TX_SEND: begin
                if (desc_done_i) begin
                    state_next.ptr = align_word(state_reg.link);
                    state_next.adv = 1'b1;
                    state_next.st  = IGTDP_TX_FETCH;
                end
            end
            IGTDP_TX_PARK: begin
                if (txe_write_i) begin
                    state_next.st = IGTDP_TX_FETCH;
                end
            end
            default: begin
                state_next.st = IGTDP_TX_IDLE;
            end
        endcase
        if (txe_write_i && !txe_value_i) begin
            state_next.st = IGTDP_TX_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.st  <= IGTDP_TX_IDLE;
            state_reg.ptr <= `IGTDP_TX_DESCRIPTOR_POINTER_RST;
            state_reg.link <= `IGTDP_LINK_RST;
            state_reg.adv <= 1'b0;
            state_reg.eol <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign fetch_req_o   = (state_reg.st == IGTDP_TX_FETCH);
    assign fetch_addr_o  = state_reg.ptr;
    assign tx_descriptor_pointer_o        = state_reg.ptr;
    assign active_o      = (state_reg.st != IGTDP_TX_IDLE);
    assign advance_o     = state_reg.adv;
    assign end_of_list_o = state_reg.eol;

endmodule

// File: core/igtdp_regs.sv
`timescale 1ns/1ns
`include "igtdp_consts.svh"

// Behaviour
// - the host interrupt line is driven only while gate bit 0 is one; bits 31..1 are unused.
// - with the gate bit zero the line stays low whatever status is pending.
// - writing the gate register leaves interrupt status and mask untouched.
// - the gate register is read-write at 0x18 and resets to zero.
// - the descriptor pointer is read-write at 0x20 while idle and read-only while active, resets to zero, bits 1..0 unused.
// - while active the pointer follows the engine along the linked list.
// - a null link holds the pointer on the current descriptor.
// - writing one to the transmit enable bit while idle or parked makes the engine refetch the link field; writing zero returns it to idle.
// - status bits set whatever the mask, and count only when their mask bit is set.

module igtdp_regs (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire igtdp_pkg::igtdp_word_type wb_dat_i,
    output igtdp_pkg::igtdp_word_type      wb_dat_o,
    output logic                           wb_ack_o,
    input  wire igtdp_pkg::igtdp_evt_type  ext_event_i,
    output logic                           fetch_req_o,
    output igtdp_pkg::igtdp_word_type      fetch_addr_o,
    input  wire logic                      fetch_ack_i,
    input  wire igtdp_pkg::igtdp_word_type link_i,
    input  wire logic                      desc_done_i,
    output logic                           tx_active_o,
    output logic                           host_interrupt_line_o
);
    import igtdp_pkg::*;

    typedef struct packed {
        logic           ack;
        igtdp_word_type rdata;
        logic           gate;
        logic           transmit_enable_bit;
    } igtdp_bus_state_type;

    igtdp_bus_state_type state_reg;
    igtdp_bus_state_type state_next;

    // ==========================================
    // bus decode nets
    logic           req;
    logic           rd;
    logic           wr;
    logic           lane0;
    logic           hit_gate;
    logic           hit_tx_descriptor_pointer;
    logic           hit_cmd;
    logic           hit_isr;
    logic           hit_imr;
    logic           wr_gate;
    logic           wr_tx_descriptor_pointer;
    logic           wr_cmd;
    logic           wr_isr;
    logic           wr_imr;
    logic           wgate;
    logic           wtxe;
    igtdp_evt_type  wevt;
    igtdp_word_type wmerged;

    // ==========================================
    // submodule nets
    igtdp_word_type tx_descriptor_pointer;
    igtdp_evt_type  status;
    igtdp_evt_type  mask;
    igtdp_evt_type  events;
    igtdp_evt_type  tx_events;
    logic           active;
    logic           adv;
    logic           eol;

    // ==========================================
    // register images
    igtdp_word_type gate_word;
    igtdp_word_type tx_descriptor_pointer_word;
    igtdp_word_type cmd_word;
    igtdp_word_type isr_word;
    igtdp_word_type imr_word;
    igtdp_word_type evraw_word;
    igtdp_word_type read_word;

    // ==========================================
    // helper functions
    function automatic logic addr_hit(input logic [7:0] adr,
                                      input logic [7:0] off);
        addr_hit = (adr == off);
    endfunction

    function automatic igtdp_word_type merge_bytes(input igtdp_word_type old,
                                                   input igtdp_word_type nw,
                                                   input logic [3:0]     sel);
        merge_bytes = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge_bytes[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    function automatic igtdp_word_type bit_word(input logic b);
        bit_word = {31'h0, b};
    endfunction

    function automatic igtdp_word_type evt_word(input igtdp_evt_type e);
        evt_word = {28'h0, e};
    endfunction

    function automatic igtdp_word_type read_mux(
        input logic [7:0]     adr,
        input igtdp_word_type gate_w,
        input igtdp_word_type tx_descriptor_pointer_w,
        input igtdp_word_type cmd_w,
        input igtdp_word_type isr_w,
        input igtdp_word_type imr_w,
        input igtdp_word_type evraw_w
    );
        case (adr)
            `IGTDP_OFF_GATE: begin
                read_mux = gate_w;
            end
            `IGTDP_OFF_TX_DESCRIPTOR_POINTER: begin
                read_mux = tx_descriptor_pointer_w;
            end
            `IGTDP_OFF_CMD: begin
                read_mux = cmd_w;
            end
            `IGTDP_OFF_ISR: begin
                read_mux = isr_w;
            end
            `IGTDP_OFF_IMR: begin
                read_mux = imr_w;
            end
            `IGTDP_OFF_EVRAW: begin
                read_mux = evraw_w;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    endfunction

    // ==========================================
    // bus decode
    assign req      = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign rd       = req && !wb_we_i;
    assign wr       = req && wb_we_i;
    assign lane0    = wb_sel_i[0];
    assign hit_gate = addr_hit(wb_adr_i, `IGTDP_OFF_GATE);
    assign hit_tx_descriptor_pointer = addr_hit(wb_adr_i, `IGTDP_OFF_TX_DESCRIPTOR_POINTER);
    assign hit_cmd  = addr_hit(wb_adr_i, `IGTDP_OFF_CMD);
    assign hit_isr  = addr_hit(wb_adr_i, `IGTDP_OFF_ISR);
    assign hit_imr  = addr_hit(wb_adr_i, `IGTDP_OFF_IMR);

    // ==========================================
    // write strobes, lane 0 for the narrow registers
    assign wr_gate = wr && hit_gate && lane0;
    assign wr_tx_descriptor_pointer = wr && hit_tx_descriptor_pointer && !active;
    assign wr_cmd  = wr && hit_cmd && lane0;
    assign wr_isr  = wr && hit_isr && lane0;
    assign wr_imr  = wr && hit_imr && lane0;
    assign wgate   = wb_dat_i[`IGTDP_GATE_EN_BIT];
    assign wtxe    = wb_dat_i[`IGTDP_CMD_TXE_BIT];
    assign wevt    = wb_dat_i[3:0];
    assign wmerged = merge_bytes(tx_descriptor_pointer,
                                 wb_dat_i,
                                 wb_sel_i);

    // ==========================================
    // transmit events feed the sticky status
    assign tx_events = {2'b00, eol, adv};
    assign events    = ext_event_i | tx_events;

    // ==========================================
    // read images
    assign gate_word  = bit_word(state_reg.gate);
    assign tx_descriptor_pointer_word  = {tx_descriptor_pointer[31:`IGTDP_TX_DESCRIPTOR_POINTER_LSB], 2'b00};
    assign cmd_word   = bit_word(state_reg.transmit_enable_bit);
    assign isr_word   = evt_word(status);
    assign imr_word   = evt_word(mask);
    assign evraw_word = bit_word(active);
    assign read_word  = read_mux(wb_adr_i,
                                 gate_word,
                                 tx_descriptor_pointer_word,
                                 cmd_word,
                                 isr_word,
                                 imr_word,
                                 evraw_word);

    // ==========================================
    // control and read path
    always_comb begin
        state_next     = state_reg;
        state_next.ack = req;
        if (wr_gate) begin
            // only the gate bit, status and mask kept
            state_next.gate = wgate;
        end
        if (wr_cmd) begin
            state_next.transmit_enable_bit = wtxe;
        end
        if (rd) begin
            state_next.rdata = read_word;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.ack   <= 1'b0;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.gate  <= `IGTDP_GATE_EN_RST;
            state_reg.transmit_enable_bit   <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================
    // submodules
    igtdp_irq_gate u_irq (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .event_i     (events),
        .clr_we_i    (wr_isr),
        .clr_data_i  (wevt),
        .mask_we_i   (wr_imr),
        .mask_data_i (wevt),
        .enable_i    (state_reg.gate),
        .irq_o       (host_interrupt_line_o),
        .status_o    (status),
        .mask_o      (mask)
    );

    igtdp_tx_walker u_walk (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .txe_write_i   (wr_cmd),
        .txe_value_i   (wtxe),
        .tx_descriptor_pointer_we_i     (wr_tx_descriptor_pointer),
        .tx_descriptor_pointer_data_i   (wmerged),
        .fetch_req_o   (fetch_req_o),
        .fetch_addr_o  (fetch_addr_o),
        .fetch_ack_i   (fetch_ack_i),
        .link_i        (link_i),
        .desc_done_i   (desc_done_i),
        .tx_descriptor_pointer_o        (tx_descriptor_pointer),
        .active_o      (active),
        .advance_o     (adv),
        .end_of_list_o (eol)
    );

    assign wb_ack_o    = state_reg.ack;
    assign wb_dat_o    = state_reg.rdata;
    assign tx_active_o = active;

endmodule

// File: dv/igtdp_properties.sv
`timescale 1ns/1ns
`include "igtdp_consts.svh"

module igtdp_properties (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [7:0]                wb_adr_i,
    input wire logic [3:0]                wb_sel_i,
    input wire igtdp_pkg::igtdp_word_type wb_dat_i,
    input wire igtdp_pkg::igtdp_word_type wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      fetch_req_o,
    input wire logic                      fetch_ack_i,
    input wire logic                      tx_active_o,
    input wire logic                      host_interrupt_line_o
);
    import igtdp_pkg::*;
    logic          gate_reg;
    igtdp_evt_type mask_reg;
    logic          wr_ok;
    logic          rd_ok;
    // write taken at the same edge as in the design
    assign wr_ok = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                   wb_sel_i[0];
    assign rd_ok = wb_ack_o && !wb_we_i;
    // ==========================================
    // shadow of gate and mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_reg <= 1'b0;
            mask_reg <= 4'h0;
        end else begin
            if (wr_ok && wb_adr_i == `IGTDP_OFF_GATE) gate_reg <= wb_dat_i[0];
            if (wr_ok && wb_adr_i == `IGTDP_OFF_IMR) mask_reg <= wb_dat_i[3:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // checks
    chk_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_gate_read: assert property (
        rd_ok && wb_adr_i == `IGTDP_OFF_GATE |-> wb_dat_o == {31'h0, gate_reg})
        else $error("gate read wrong");
    chk_ptr_low: assert property (
        rd_ok && wb_adr_i == `IGTDP_OFF_TX_DESCRIPTOR_POINTER |-> wb_dat_o[1:0] == 2'b00)
        else $error("pointer low bits set");
    chk_irq_gated: assert property (
        host_interrupt_line_o |-> $past(gate_reg)) else $error("irq ungated");
    chk_irq_masked: assert property (
        host_interrupt_line_o |-> mask_reg != 4'h0)
        else $error("irq while all masked");
    chk_txe_refetch: assert property (
        wr_ok && wb_adr_i == `IGTDP_OFF_CMD && wb_dat_i[0] && !tx_active_o
        |-> ##[1:3] fetch_req_o) else $error("no fetch after enable");
    chk_fetch_hold: assert property (
        fetch_req_o && !fetch_ack_i && !(wr_ok && wb_adr_i == `IGTDP_OFF_CMD)
        |=> fetch_req_o && tx_active_o)
        else $error("fetch dropped");
    cover property (host_interrupt_line_o);
    cover property (fetch_ack_i);
    cover property (wr_ok && wb_adr_i == `IGTDP_OFF_CMD);
endmodule

bind igtdp_regs igtdp_properties chk_u (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .fetch_req_o, .fetch_ack_i, .tx_active_o,
    .host_interrupt_line_o);

// File: dv/igtdp_mem_model.sv
`timescale 1ns/1ns

module igtdp_mem_model (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      fetch_req_i,
    input  wire igtdp_pkg::igtdp_word_type fetch_addr_i,
    input  wire logic [3:0]                delay_i,
    output logic                           fetch_ack_o,
    output igtdp_pkg::igtdp_word_type      link_o,
    output logic                           desc_done_o
);
    import igtdp_pkg::*;
    igtdp_word_type link_mem [0:63] = '{default: 32'h0};
    logic [3:0]     wait_cnt;
    logic           sending;
    // ==========================================
    // link answers and descriptor sending
    always_ff @(posedge clk_i) begin
        fetch_ack_o <= 1'b0;
        desc_done_o <= 1'b0;
        link_o      <= ~link_o;
        if (rst_i) begin
            wait_cnt <= 4'h0;
            sending  <= 1'b0;
            link_o   <= 32'h0;
        end else if (sending || (fetch_req_i && !fetch_ack_o)) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == delay_i) begin
                wait_cnt <= 4'h0;
                sending  <= 1'b0;
                if (sending) begin
                    desc_done_o <= 1'b1;
                end else begin
                    fetch_ack_o <= 1'b1;
                    link_o      <= link_mem[fetch_addr_i[7:2]];
                    sending     <= |link_mem[fetch_addr_i[7:2]];
                end
            end
        end
    end
endmodule

// File: dv/host_interrupt_line_gate_tx_desc_pointer_bench.sv
`timescale 1ns/1ns
`include "igtdp_consts.svh"

module host_interrupt_line_gate_tx_desc_pointer_bench;
    import igtdp_pkg::*;
    logic           clk_i    = 1'b0;
    logic           rst_i    = 1'b1;
    logic           wb_cyc_i = 1'b0;
    logic           wb_stb_i = 1'b0;
    logic           wb_we_i  = 1'b0;
    logic [7:0]     wb_adr_i = 8'h00;
    logic [3:0]     wb_sel_i = 4'h0;
    igtdp_word_type wb_dat_i = 32'h0;
    igtdp_evt_type  ext_event_i = 4'h0;
    logic [3:0]     delay    = 4'h0;
    igtdp_word_type wb_dat_o, fetch_addr_o, link_i, rdat;
    logic           wb_ack_o, fetch_req_o, fetch_ack_i, desc_done_i;
    logic           tx_active_o, host_interrupt_line_o;
    int             n_mismatch  = 0;
    int             checks_done = 0;
    always #5 clk_i = ~clk_i;
    igtdp_regs dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_event_i,
        .fetch_req_o, .fetch_addr_o, .fetch_ack_i, .link_i, .desc_done_i,
        .tx_active_o, .host_interrupt_line_o);
    igtdp_mem_model mem_u (.clk_i, .rst_i, .fetch_req_i(fetch_req_o),
        .fetch_addr_i(fetch_addr_o), .delay_i(delay), .link_o(link_i),
        .fetch_ack_o(fetch_ack_i), .desc_done_o(desc_done_i));
    // ==========================================
    // helpers
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input igtdp_word_type seen, input igtdp_word_type exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
                       input igtdp_word_type d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input igtdp_word_type exp);
        bus(a, 1'b0, 32'h0);
        check(rdat, exp);
    endtask
    task automatic irq(input logic exp);
        repeat (3) @(negedge clk_i);
        check({31'h0, host_interrupt_line_o}, {31'h0, exp});
    endtask
    task automatic poll(input logic [7:0] a, input igtdp_word_type exp);
        int i;
        i = 0;
        do begin
            bus(a, 1'b0, 32'h0);
            i++;
        end while (rdat !== exp && i < 40);
        check(rdat, exp);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end
    // ==========================================
    // sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`IGTDP_OFF_GATE, 32'h0);
        rd(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'h0);
        rd(8'h3c, 32'h0);
        bus(`IGTDP_OFF_GATE, 1'b1, 32'hffff_ffff);
        rd(`IGTDP_OFF_GATE, 32'h1);
        bus(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 1'b1, 32'hdead_beef);
        rd(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'hdead_beec);
        bus(`IGTDP_OFF_GATE, 1'b1, 32'h0);
        bus(`IGTDP_OFF_IMR, 1'b1, 32'h4);
        ext_event_i <= 4'h6;
        @(posedge clk_i);
        ext_event_i <= 4'h0;
        irq(1'b0);
        rd(`IGTDP_OFF_ISR, 32'h6);
        bus(`IGTDP_OFF_GATE, 1'b1, 32'h1);
        irq(1'b1);
        bus(`IGTDP_OFF_GATE, 1'b1, 32'h0);
        irq(1'b0);
        rd(`IGTDP_OFF_ISR, 32'h6);
        rd(`IGTDP_OFF_IMR, 32'h4);
        bus(`IGTDP_OFF_IMR, 1'b1, 32'h0);
        bus(`IGTDP_OFF_GATE, 1'b1, 32'h1);
        irq(1'b0);
        bus(`IGTDP_OFF_IMR, 1'b1, 32'h2);
        irq(1'b1);
        bus(`IGTDP_OFF_ISR, 1'b1, 32'h6);
        irq(1'b0);
        mem_u.link_mem[16] = 32'h80;
        bus(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 1'b1, 32'h40);
        delay <= 4'h3;
        bus(`IGTDP_OFF_CMD, 1'b1, 32'h1);
        poll(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'h80);
        poll(`IGTDP_OFF_ISR, 32'h3);
        repeat (20) @(posedge clk_i);
        rd(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'h80);
        check({31'h0, tx_active_o}, 32'h1);
        bus(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 1'b1, 32'h100);
        rd(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'h80);
        mem_u.link_mem[32] = 32'hc0;
        delay <= 4'h0;
        bus(`IGTDP_OFF_CMD, 1'b1, 32'h1);
        poll(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'hc0);
        bus(`IGTDP_OFF_CMD, 1'b1, 32'h0);
        poll(`IGTDP_OFF_EVRAW, 32'h0);
        bus(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 1'b1, 32'h44);
        rd(`IGTDP_OFF_TX_DESCRIPTOR_POINTER, 32'h44);
        finish_test();
    end
endmodule
